// file: logic/scd_cfg.svh
// Named offsets, codes and counts shared by both ends of the dictionary link.
// Assumes it is included by bare name from logic/ and testbench/ files.
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_IDX_IN6    16'h2C00
`define SCD_IDX_OUT6   16'h2D00
`define SCD_IDX_IN8    16'h3000
`define SCD_IDX_OUT8   16'h3100
`define SCD_IDX_RACC   16'h4500
`define SCD_LAST_REQ   4'hB
`define SCD_LAST_RSP   4'h8
`define SCD_ST_OK      8'h00
`define SCD_ST_NOOBJ   8'h01
`define SCD_ST_SUB     8'h02
`define SCD_ST_RO      8'h03
`define SCD_ST_ACC     8'h04
`define SCD_ST_PROT    8'h05
`define SCD_UNLOCK_TBL 7'h63
`define SCD_UNLK_R0    8'h02
`define SCD_UNLK_V0    16'hAFFE
`define SCD_UNLK_R1    8'h01
`define SCD_UNLK_V1    16'h0001
`define SCD_UNLK_R2    8'h00
`define SCD_UNLK_V2    16'h0101
`define SCD_UNLOCKED   2'h3
`define SCD_A_CTRL     8'h00
`define SCD_A_INDEX    8'h04
`define SCD_A_WLO      8'h08
`define SCD_A_WHI      8'h0C
`define SCD_A_STAT     8'h10
`define SCD_A_RLO      8'h14
`define SCD_A_RHI      8'h18
`define SCD_RESP_OK    2'h0
`define SCD_RESP_ERR   2'h2
`endif

// file: logic/scd_pkg.sv
// Types shared by the dictionary device and the link master.
// Assumes scd_cfg.svh supplies all numeric constants.
`default_nettype none
package scd_pkg;
  // Device sequencer: collect request, execute, wait for register port, answer.
  typedef enum logic [3:0] {
    SCD_D_RX   = 4'h1,
    SCD_D_EXEC = 4'h2,
    SCD_D_REG  = 4'h4,
    SCD_D_TX   = 4'h8
  } scd_dev_st_e;
  // Master sequencer: idle, send request bytes, receive answer bytes.
  typedef enum logic [2:0] {
    SCD_M_IDLE = 3'h1,
    SCD_M_SEND = 3'h2,
    SCD_M_RECV = 3'h4
  } scd_mst_st_e;
  typedef logic [7:0] scd_byte_t;
endpackage
`default_nettype wire

// file: logic/scd_link_if.sv
// Byte link between the dictionary master and the dictionary device.
// Assumes both ends run on one clock; each byte moves when valid and ready are high.
`timescale 1ns/1ps
`default_nettype none
interface scd_link_if;
  logic              req_valid;  // Master offers a request byte.
  logic              req_ready;  // Device takes the request byte.
  scd_pkg::scd_byte_t req_byte;   // Request byte, least significant first.
  logic              rsp_valid;  // Device offers an answer byte.
  logic              rsp_ready;  // Master takes the answer byte.
  scd_pkg::scd_byte_t rsp_byte;   // Answer byte, status first then data.
  modport dev (input req_valid, req_byte, rsp_ready, output req_ready, rsp_valid, rsp_byte);
  modport mst (output req_valid, req_byte, rsp_ready, input req_ready, rsp_valid, rsp_byte);
endinterface
`default_nettype wire

// file: logic/scd_device.sv
// Dictionary device: wide special channels and the register-access object.
// Assumes the master sends 12-byte requests and takes 9-byte answers in order.
`timescale 1ns/1ps
`default_nettype none
`include "scd_cfg.svh"
module scd_device #(
  parameter logic [7:0] CNT_IN6  = 8'h40,  // Fitted 6-byte input channels.
  parameter logic [7:0] CNT_OUT6 = 8'h40,  // Fitted 6-byte output channels.
  parameter logic [7:0] CNT_IN8  = 8'h40,  // Fitted 8-byte input channels.
  parameter logic [7:0] CNT_OUT8 = 8'h40   // Fitted 8-byte output channels.
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  scd_link_if.dev            link,
  input  wire logic          in6_we,
  input  wire logic          in8_we,
  input  wire logic [5:0]    in_ch,
  input  wire logic [63:0]   in_data,
  input  wire logic [5:0]    out_ch,
  output logic      [47:0]   out6_q,
  output logic      [63:0]   out8_q,
  output logic               reg_req,
  output logic               reg_we,
  output logic      [6:0]    reg_tbl,
  output logic      [7:0]    reg_addr,
  output logic      [15:0]   reg_wdata,
  input  wire logic          reg_ack,
  input  wire logic          reg_err,
  input  wire logic [15:0]   reg_rdata
);
  import scd_pkg::*;

  logic [47:0] in6_mem  [64];  // Input channels of six bytes.
  logic [47:0] out6_mem [64];  // Output channels of six bytes.
  logic [63:0] in8_mem  [64];  // Input channels of eight bytes.
  logic [63:0] out8_mem [64];  // Output channels of eight bytes.

  scd_dev_st_e st_reg, st_next;        // Sequencer state.
  logic [3:0]  cnt_reg, cnt_next;      // Byte counter within a frame.
  logic [95:0] rx_reg, rx_next;        // Request bytes, first byte lowest.
  logic [71:0] tx_reg, tx_next;        // Answer: status in the low byte.
  logic        flag_reg, flag_next;    // Access flag shown to the master.
  logic [6:0]  tbl_reg, tbl_next;      // Latched table number.
  logic [7:0]  adr_reg, adr_next;      // Latched register number.
  logic [15:0] val_reg, val_next;      // Last register value.
  logic [1:0]  lock_reg, lock_next;    // Unlock progress, three means open.
  logic        we_reg, we_next;        // Pending port access is a write.
  logic        w6, w8;                 // Output channel write strobes.
  logic [5:0]  w_ch;                   // Channel written.

  // Request fields, assembled least significant byte first.
  logic        f_wr;
  logic [15:0] f_idx;
  logic [7:0]  f_sub;
  logic [63:0] f_dat;
  logic [7:0]  f_cnt;
  logic [5:0]  f_ch;
  logic        f_in, f_chan, f_wide;
  assign f_wr  = rx_reg[0];
  assign f_idx = rx_reg[23:8];
  assign f_sub = rx_reg[31:24];
  assign f_dat = rx_reg[95:32];
  assign f_ch  = 6'(f_sub - 8'h01);
  assign f_in  = (f_idx == `SCD_IDX_IN6) || (f_idx == `SCD_IDX_IN8);
  assign f_wide = (f_idx == `SCD_IDX_IN8) || (f_idx == `SCD_IDX_OUT8);
  assign f_chan = f_in || (f_idx == `SCD_IDX_OUT6) || (f_idx == `SCD_IDX_OUT8);

  // Count of fitted channels for the addressed object.
  always_comb begin
    case (f_idx)
      `SCD_IDX_IN6:  f_cnt = CNT_IN6;
      `SCD_IDX_OUT6: f_cnt = CNT_OUT6;
      `SCD_IDX_IN8:  f_cnt = CNT_IN8;
      default:       f_cnt = CNT_OUT8;
    endcase
  end

  // Link handshakes follow the state; the answer byte comes from a flop.
  assign link.req_ready = (st_reg == SCD_D_RX);
  assign link.rsp_valid = (st_reg == SCD_D_TX);
  assign link.rsp_byte  = tx_reg[7:0];
  assign reg_req   = (st_reg == SCD_D_REG);
  assign reg_we    = we_reg;
  assign reg_tbl   = tbl_reg;
  assign reg_addr  = adr_reg;
  assign reg_wdata = val_reg;

  // Next-state logic for the sequencer and the access word.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    rx_next   = rx_reg;
    tx_next   = tx_reg;
    flag_next = flag_reg;
    tbl_next  = tbl_reg;
    adr_next  = adr_reg;
    val_next  = val_reg;
    lock_next = lock_reg;
    we_next   = we_reg;
    w6 = 1'b0;
    w8 = 1'b0;
    w_ch = f_ch;
    case (st_reg)
      SCD_D_RX: begin
        // Shift bytes in from the top so the first ends lowest.
        if (link.req_valid) begin
          rx_next = {link.req_byte, rx_reg[95:8]};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `SCD_LAST_REQ) begin
            cnt_next = 4'h0;
            st_next = SCD_D_EXEC;
          end
        end
      end
      SCD_D_EXEC: begin
        st_next = SCD_D_TX;
        tx_next = {64'h0, `SCD_ST_OK};
        if (f_idx == `SCD_IDX_RACC) begin
          if (f_sub != 8'h00) begin
            tx_next[7:0] = `SCD_ST_SUB;
          end else if (!f_wr) begin
            // One word carries flag, table, register and value.
            tx_next[39:8] = {flag_reg, tbl_reg, adr_reg, val_reg};
          end else if (!f_dat[31]) begin
            // Read request: low bytes ignored, flag set until value valid.
            tbl_next = f_dat[30:24];
            adr_next = f_dat[23:16];
            flag_next = 1'b1;
            we_next = 1'b0;
            st_next = SCD_D_REG;
          end else if ((lock_reg != `SCD_UNLOCKED) && (f_dat[30:24] != `SCD_UNLOCK_TBL)) begin
            tx_next[7:0] = `SCD_ST_PROT;
          end else begin
            tbl_next = f_dat[30:24];
            adr_next = f_dat[23:16];
            val_next = f_dat[15:0];
            flag_next = 1'b1;
            we_next = 1'b1;
            st_next = SCD_D_REG;
            // Track the three-step unlock; any other table-99 write restarts it.
            if (f_dat[30:24] == `SCD_UNLOCK_TBL && lock_reg != `SCD_UNLOCKED) begin
              lock_next = 2'h0;
              if (lock_reg == 2'h0 && f_dat[23:0] == {`SCD_UNLK_R0, `SCD_UNLK_V0}) begin
                lock_next = 2'h1;
              end else if (lock_reg == 2'h1 && f_dat[23:0] == {`SCD_UNLK_R1, `SCD_UNLK_V1}) begin
                lock_next = 2'h2;
              end else if (lock_reg == 2'h2 && f_dat[23:0] == {`SCD_UNLK_R2, `SCD_UNLK_V2}) begin
                lock_next = `SCD_UNLOCKED;
              end
            end
          end
        end else if (!f_chan) begin
          tx_next[7:0] = `SCD_ST_NOOBJ;
        end else if (f_sub == 8'h00) begin
          // The count is read-only for every channel object.
          if (f_wr) begin
            tx_next[7:0] = `SCD_ST_RO;
          end else begin
            tx_next[15:8] = f_cnt;
          end
        end else if (f_sub > f_cnt) begin
          tx_next[7:0] = `SCD_ST_SUB;
        end else if (f_wr && f_in) begin
          tx_next[7:0] = `SCD_ST_RO;
        end else if (f_wr) begin
          w6 = !f_wide;
          w8 = f_wide;
        end else begin
          case (f_idx)
            `SCD_IDX_IN6:  tx_next[71:8] = {16'h0, in6_mem[f_ch]};
            `SCD_IDX_OUT6: tx_next[71:8] = {16'h0, out6_mem[f_ch]};
            `SCD_IDX_IN8:  tx_next[71:8] = in8_mem[f_ch];
            default:       tx_next[71:8] = out8_mem[f_ch];
          endcase
        end
      end
      SCD_D_REG: begin
        // Hold the port request until the station answers.
        if (reg_ack) begin
          flag_next = 1'b0;
          if (!we_reg) val_next = reg_rdata;
          tx_next = {64'h0, reg_err ? `SCD_ST_ACC : `SCD_ST_OK};
          st_next = SCD_D_TX;
        end
      end
      SCD_D_TX: begin
        if (link.rsp_ready) begin
          tx_next = {8'h00, tx_reg[71:8]};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `SCD_LAST_RSP) begin
            cnt_next = 4'h0;
            st_next = SCD_D_RX;
          end
        end
      end
      default: begin
        st_next = SCD_D_RX;
        cnt_next = 4'h0;
      end
    endcase
  end

  // Register stage for the sequencer; the clock enable freezes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= SCD_D_RX;
      cnt_reg  <= 4'h0;
      rx_reg   <= 96'h0;
      tx_reg   <= 72'h0;
      flag_reg <= 1'b0;
      tbl_reg  <= 7'h00;
      adr_reg  <= 8'h00;
      val_reg  <= 16'h0000;
      lock_reg <= 2'h0;
      we_reg   <= 1'b0;
    end else if (ce) begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      rx_reg   <= rx_next;
      tx_reg   <= tx_next;
      flag_reg <= flag_next;
      tbl_reg  <= tbl_next;
      adr_reg  <= adr_next;
      val_reg  <= val_next;
      lock_reg <= lock_next;
      we_reg   <= we_next;
    end
  end

  // Channel memories: all clear at reset, inputs fed by the station side.
  // Resetting every entry costs flops, not RAM, but zero reset is required.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 64; i++) begin
        in6_mem[i]  <= 48'h0;
        out6_mem[i] <= 48'h0;
        in8_mem[i]  <= 64'h0;
        out8_mem[i] <= 64'h0;
      end
      out6_q <= 48'h0;
      out8_q <= 64'h0;
    end else if (ce) begin
      if (in6_we) in6_mem[in_ch] <= in_data[47:0];
      if (in8_we) in8_mem[in_ch] <= in_data;
      if (w6) out6_mem[w_ch] <= f_dat[47:0];
      if (w8) out8_mem[w_ch] <= f_dat;
      out6_q <= out6_mem[out_ch];
      out8_q <= out8_mem[out_ch];
    end
  end
endmodule
`default_nettype wire

// file: logic/scd_master.sv
// Link master: software orders one dictionary transfer at a time over AXI4-Lite.
// Assumes an AXI4-Lite master on the same clock and a scd_device on the link.
`timescale 1ns/1ps
`default_nettype none
`include "scd_cfg.svh"
module scd_master (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  scd_link_if.mst          link,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic      [1:0]  s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic      [31:0] s_rdata,
  output logic      [1:0]  s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  import scd_pkg::*;

  scd_mst_st_e st_reg, st_next;      // Transfer state.
  logic [3:0]  cnt_reg, cnt_next;    // Byte counter.
  logic [95:0] tx_reg, tx_next;      // Request shift register.
  logic [71:0] rx_reg, rx_next;      // Answer shift register.
  logic        wr_reg, wr_next;      // Transfer is a write.
  logic [23:0] idx_reg, idx_next;    // Sub-index and index.
  logic [63:0] wd_reg, wd_next;      // Write data.
  logic        done_reg, done_next;  // Sticky completion flag.
  logic        bv_reg, bv_next;      // Write response pending.
  logic [1:0]  br_reg, br_next;      // Write response code.
  logic        rv_reg, rv_next;      // Read response pending.
  logic [31:0] rd_reg, rd_next;      // Read data.
  logic [1:0]  rr_reg, rr_next;      // Read response code.
  logic        wr_go, rd_go;         // Bus accesses taken this cycle.
  logic [31:0] wmask;                // Byte-lane mask from the strobes.

  // Write address and data are taken together; reads wait for rvalid to clear.
  assign wr_go = s_awvalid && s_wvalid && !bv_reg;
  assign rd_go = s_arvalid && !rv_reg;
  assign s_awready = wr_go;
  assign s_wready  = wr_go;
  assign s_arready = !rv_reg;
  assign s_bvalid  = bv_reg;
  assign s_bresp   = br_reg;
  assign s_rvalid  = rv_reg;
  assign s_rdata   = rd_reg;
  assign s_rresp   = rr_reg;
  assign link.req_valid = (st_reg == SCD_M_SEND);
  assign link.req_byte  = tx_reg[7:0];
  assign link.rsp_ready = (st_reg == SCD_M_RECV);

  // Expand write strobes into a bit mask, one generate lane per byte.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{s_wstrb[g]}};
  end

  // Next values for bus registers and the link sequencer.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    wr_next = wr_reg;
    idx_next = idx_reg;
    wd_next = wd_reg;
    done_next = done_reg;
    bv_next = bv_reg && !s_bready;
    br_next = br_reg;
    rv_next = rv_reg && !s_rready;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (wr_go) begin
      bv_next = 1'b1;
      br_next = `SCD_RESP_OK;
      case (s_awaddr)
        `SCD_A_INDEX: idx_next = (idx_reg & ~wmask[23:0]) | (s_wdata[23:0] & wmask[23:0]);
        `SCD_A_WLO:   wd_next[31:0] = (wd_reg[31:0] & ~wmask) | (s_wdata & wmask);
        `SCD_A_WHI:   wd_next[63:32] = (wd_reg[63:32] & ~wmask) | (s_wdata & wmask);
        `SCD_A_CTRL: begin
          // Start is ignored while a transfer is under way.
          if (s_wstrb[0] && s_wdata[0] && st_reg == SCD_M_IDLE) begin
            wr_next = s_wdata[1];
            tx_next = {wd_reg, idx_reg, 7'h00, s_wdata[1]};
            done_next = 1'b0;
            cnt_next = 4'h0;
            st_next = SCD_M_SEND;
          end
        end
        `SCD_A_STAT, `SCD_A_RLO, `SCD_A_RHI: ;
        default: br_next = `SCD_RESP_ERR;
      endcase
    end
    if (rd_go) begin
      rv_next = 1'b1;
      rr_next = `SCD_RESP_OK;
      case (s_araddr)
        `SCD_A_CTRL:  rd_next = {30'h0, wr_reg, 1'b0};
        `SCD_A_INDEX: rd_next = {8'h00, idx_reg};
        `SCD_A_WLO:   rd_next = wd_reg[31:0];
        `SCD_A_WHI:   rd_next = wd_reg[63:32];
        `SCD_A_STAT:  rd_next = {16'h0, rx_reg[7:0], 6'h00, done_reg, st_reg != SCD_M_IDLE};
        `SCD_A_RLO:   rd_next = rx_reg[39:8];
        `SCD_A_RHI:   rd_next = rx_reg[71:40];
        default: begin
          rd_next = 32'h0;
          rr_next = `SCD_RESP_ERR;
        end
      endcase
    end
    case (st_reg)
      SCD_M_IDLE: ;
      SCD_M_SEND: begin
        if (link.req_ready) begin
          tx_next = {8'h00, tx_reg[95:8]};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `SCD_LAST_REQ) begin
            cnt_next = 4'h0;
            st_next = SCD_M_RECV;
          end
        end
      end
      SCD_M_RECV: begin
        if (link.rsp_valid) begin
          rx_next = {link.rsp_byte, rx_reg[71:8]};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `SCD_LAST_RSP) begin
            done_next = 1'b1;
            st_next = SCD_M_IDLE;
          end
        end
      end
      default: st_next = SCD_M_IDLE;
    endcase
  end

  // Register stage; the clock enable freezes every flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= SCD_M_IDLE;
      cnt_reg <= 4'h0;
      tx_reg <= 96'h0;
      rx_reg <= 72'h0;
      wr_reg <= 1'b0;
      idx_reg <= 24'h0;
      wd_reg <= 64'h0;
      done_reg <= 1'b0;
      bv_reg <= 1'b0;
      br_reg <= 2'h0;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= 2'h0;
    end else if (ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      wr_reg <= wr_next;
      idx_reg <= idx_next;
      wd_reg <= wd_next;
      done_reg <= done_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end
endmodule
`default_nettype wire

// file: testbench/scd_link_monitor.sv
// Concurrent checks on the byte link between dictionary master and device.
// Assumes one clock; both link ends are design modules.
`timescale 1ns/1ps
`default_nettype none
module scd_link_monitor (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire scd_pkg::scd_byte_t req_byte,
  input wire logic               rsp_valid,
  input wire logic               rsp_ready,
  input wire scd_pkg::scd_byte_t rsp_byte
);
  import scd_pkg::*;
  logic [3:0] rq_reg;  // Request bytes taken in this frame.
  logic [3:0] rs_reg;  // Answer bytes taken in this frame.
  logic       er_reg;  // The answer in flight carries an error status.
  logic       rq_t;    // A request byte moves.
  logic       rs_t;    // An answer byte moves.
  assign rq_t = req_valid && req_ready && ce;
  assign rs_t = rsp_valid && rsp_ready && ce;
  // Frame counters wrap, so a lost byte shows as misalignment.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rq_reg <= 4'h0;
      rs_reg <= 4'h0;
      er_reg <= 1'b0;
    end else begin
      if (rq_t) rq_reg <= (rq_reg == 4'hB) ? 4'h0 : rq_reg + 4'h1;
      if (rs_t) rs_reg <= (rs_reg == 4'h8) ? 4'h0 : rs_reg + 4'h1;
      if (rs_t && rs_reg == 4'h0) er_reg <= (rsp_byte != 8'h00);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  port_excl_a: assert property (!(rsp_valid && req_ready))
    else $error("answer while taking requests");
  rsp_hold_a: assert property (rsp_valid && !rs_t |=> rsp_valid && $stable(rsp_byte))
    else $error("answer byte changed before taken");
  req_hold_a: assert property (req_valid && !rq_t |=> req_valid && $stable(req_byte))
    else $error("request byte changed before taken");
  req_end_a: assert property (rq_t && rq_reg == 4'hB |=> !req_ready)
    else $error("request port open after last byte");
  rsp_end_a: assert property (rs_t && rs_reg == 4'h8 |=> req_ready && !rsp_valid)
    else $error("link busy after last answer");
  answer_soon_a: assert property (rq_t && rq_reg == 4'hB |-> ##[2:20] rsp_valid)
    else $error("answer late");
  status_range_a: assert property (rsp_valid && rs_reg == 4'h0 |-> rsp_byte <= 8'h05)
    else $error("status code out of range");
  err_zero_a: assert property (rsp_valid && rs_reg != 4'h0 && er_reg |-> rsp_byte == 8'h00)
    else $error("data nonzero after error status");
  op_byte_a: assert property (req_valid && rq_reg == 4'h0 |-> req_byte[7:1] == 7'h00)
    else $error("operation byte has stray bits");
  cover property (rs_t && rs_reg == 4'h0 && rsp_byte == 8'h03);
  cover property (rs_t && rs_reg == 4'h0 && rsp_byte == 8'h04);
  cover property (rs_t && rs_reg == 4'h0 && rsp_byte == 8'h05);
endmodule
`default_nettype wire

// file: testbench/special_channel_dictionary_regaccess_tb_top.sv
// Self-checking bench: AXI4-Lite orders reach the device through the master.
// Assumes both design ends; the bench plays the station registers.
`timescale 1ns/1ps
`default_nettype none
`include "scd_cfg.svh"
module special_channel_dictionary_regaccess_tb_top;
  import scd_pkg::*;
  logic        aclk = 0, aresetn = 0, in6_we = 0, in8_we = 0, reg_ack = 0, reg_err = 0;
  logic [5:0]  in_ch = 0, out_ch = 0;
  logic [63:0] in_data = 0, out8_q, d, msk;
  logic [47:0] out6_q;
  logic        reg_req, reg_we, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [6:0]  reg_tbl, t;
  logic [7:0]  reg_addr, s_awaddr = 0, s_araddr = 0, a, sb;
  logic [15:0] reg_wdata, reg_rdata = 0, ix [4];
  logic [31:0] s_wdata = 0, s_rdata, v, seed = 32'h58F5D082;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [30:0] last_w;  // Last port write.
  logic [14:0] last_r;  // Last port read address.
  int          miscompares = 0, samples_checked = 0, fwd_n = 0, f0;
  scd_link_if link ();
  always #10 aclk = ~aclk;
  scd_device i_scd_device (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(link), .in6_we(in6_we),
    .in8_we(in8_we), .in_ch(in_ch), .in_data(in_data), .out_ch(out_ch), .out6_q(out6_q), .out8_q(out8_q),
    .reg_req(reg_req), .reg_we(reg_we), .reg_tbl(reg_tbl), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata));
  scd_master i_scd_master (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(link), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  scd_link_monitor i_scd_link_monitor (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_byte(link.req_byte), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_byte(link.rsp_byte));
  // Xorshift source with a fixed seed.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Station register contents, a fixed pattern.
  function automatic logic [15:0] fval(input logic [6:0] tb, input logic [7:0] ad);
    return {tb, 1'b0, ad} ^ 16'h5A3C;
  endfunction
  // Station register port: ack one cycle after request; table 0x7E fails.
  always @(posedge aclk) begin
    reg_ack <= reg_req && !reg_ack;
    if (reg_req && !reg_ack) begin
      reg_err <= (reg_tbl == 7'h7E);
      reg_rdata <= fval(reg_tbl, reg_addr);
      if (reg_we) begin
        fwd_n <= fwd_n + 1;
        last_w <= {reg_tbl, reg_addr, reg_wdata};
      end else begin
        last_r <= {reg_tbl, reg_addr};
      end
    end
  end
  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_st(input logic [7:0] e, input logic [7:0] g);
    chk("answer status", e, g);
  endtask
  // A wait that ran out ends the run as a failure.
  task tmo(input int n);
    if (n >= 200) begin
      miscompares++;
      $display("mismatch handshake expected answer seen timeout");
      end_sim();
    end
  endtask
  task axi_wr(input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge aclk);
    s_awaddr <= ad;
    s_wdata <= wd;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_awready !== 1'b1 && n < 200);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (s_bvalid !== 1'b1 && n < 200);
    s_bready <= 1'b0;
    tmo(n);
  endtask
  task axi_rd(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] rr);
    int n;
    @(posedge aclk);
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_arready !== 1'b1 && n < 200);
    s_arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (s_rvalid !== 1'b1 && n < 200);
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
    tmo(n);
  endtask
  // One transfer; checks status, and data for reads and refusals.
  task tx(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [63:0] wd,
          input logic [7:0] es, input logic [63:0] eq);
    logic [31:0] st;
    logic [63:0] q;
    int n;
    axi_wr(`SCD_A_INDEX, {8'h00, sub, idx});
    axi_wr(`SCD_A_WLO, wd[31:0]);
    axi_wr(`SCD_A_WHI, wd[63:32]);
    axi_wr(`SCD_A_CTRL, {30'h0, w, 1'b1});
    st = 0;
    for (n = 0; n < 200 && st[1] !== 1'b1; n++) axi_rd(`SCD_A_STAT, st, r);
    tmo(n);
    axi_rd(`SCD_A_RLO, q[31:0], r);
    axi_rd(`SCD_A_RHI, q[63:32], r);
    chk_st(es, st[15:8]);
    if (!w || es != `SCD_ST_OK) chk("answer data", eq, q);
  endtask
  initial begin
    ix = '{`SCD_IDX_IN6, `SCD_IDX_OUT6, `SCD_IDX_IN8, `SCD_IDX_OUT8};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Counts, then first and last channel per object.
    for (int i = 0; i < 8; i++) begin
      tx(0, ix[i % 4], 8'h00, 64'h0, `SCD_ST_OK, 64'h40);
      sb = (i < 4) ? 8'h01 : 8'h40;
      msk = (i % 4 < 2) ? 64'h0000_FFFF_FFFF_FFFF : '1;
      d = {rnd(), rnd()};
      if (i % 2 == 0) begin
        in_ch <= sb[5:0] - 6'h1;
        in_data <= d;
        in6_we <= (i % 4 == 0);
        in8_we <= (i % 4 == 2);
        @(posedge aclk);
        in6_we <= 1'b0;
        in8_we <= 1'b0;
        tx(0, ix[i % 4], sb, 64'h0, `SCD_ST_OK, d & msk);
        tx(1, ix[i % 4], sb, ~d, `SCD_ST_RO, 64'h0);
        tx(0, ix[i % 4], sb, 64'h0, `SCD_ST_OK, d & msk);
      end else begin
        tx(0, ix[i % 4], sb, 64'h0, `SCD_ST_OK, 64'h0);
        tx(1, ix[i % 4], sb, d, `SCD_ST_OK, 64'h0);
        tx(0, ix[i % 4], sb, 64'h0, `SCD_ST_OK, d & msk);
        out_ch <= sb[5:0] - 6'h1;
        repeat (2) @(posedge aclk);
        chk("output port", d & msk, (i % 4 == 1) ? {16'h0, out6_q} : out8_q);
      end
    end
    tx(1, `SCD_IDX_IN6, 8'h00, 64'h5, `SCD_ST_RO, 64'h0);
    tx(0, `SCD_IDX_IN8, 8'h41, 64'h0, `SCD_ST_SUB, 64'h0);
    tx(0, `SCD_IDX_RACC, 8'h01, 64'h0, `SCD_ST_SUB, 64'h0);
    tx(0, 16'h2E00, 8'h00, 64'h0, `SCD_ST_NOOBJ, 64'h0);
    // Register reads: order with flag clear, then fetch the value.
    repeat (3) begin
      v = rnd();
      t = v[30:24] & 7'h3F;
      a = v[23:16];
      tx(1, `SCD_IDX_RACC, 8'h00, {32'h0, 1'b0, t, a, v[15:0]}, `SCD_ST_OK, 64'h0);
      chk("port read", {t, a}, last_r);
      tx(0, `SCD_IDX_RACC, 8'h00, 64'h0, `SCD_ST_OK, {32'h0, 1'b0, t, a, fval(t, a)});
    end
    tx(1, `SCD_IDX_RACC, 8'h00, 64'h7E00_0000, `SCD_ST_ACC, 64'h0);
    // Writes blocked until the three unlock steps land in order.
    f0 = fwd_n;
    tx(1, `SCD_IDX_RACC, 8'h00, 64'h8510_1234, `SCD_ST_PROT, 64'h0);
    chk("forwarded writes", f0, fwd_n);
    tx(1, `SCD_IDX_RACC, 8'h00, 64'hE302_AFFE, `SCD_ST_OK, 64'h0);
    tx(1, `SCD_IDX_RACC, 8'h00, 64'hE301_0001, `SCD_ST_OK, 64'h0);
    tx(1, `SCD_IDX_RACC, 8'h00, 64'hE300_0101, `SCD_ST_OK, 64'h0);
    tx(1, `SCD_IDX_RACC, 8'h00, 64'h8510_1234, `SCD_ST_OK, 64'h0);
    chk("forwarded word", {7'h05, 8'h10, 16'h1234}, last_w);
    chk("forwarded writes", f0 + 4, fwd_n);
    axi_rd(8'h20, v, r);
    chk("unmapped resp", `SCD_RESP_ERR, r);
    end_sim();
  end
endmodule
`default_nettype wire
